/* File: timer_buffer_event_control_consts.svh */
`ifndef TIMER_BUFFER_EVENT_CONTROL_CONSTS_SVH
`define TIMER_BUFFER_EVENT_CONTROL_CONSTS_SVH

// register indices; byte address is four times the index
`define IDX_CTRL_CLEAR 6'h04
`define IDX_CTRL_SET 6'h05
`define IDX_BV_CLEAR 6'h06
`define IDX_BV_SET 6'h07
`define IDX_EV_CTRL 6'h09
`define IDX_INT_EN 6'h0a
`define IDX_INT_FLAGS 6'h0b

// field positions
`define CTRL_DIR_BIT 0
`define CTRL_LOCK_BIT 1
`define CTRL_CMD_LSB 2
`define BV_PER_BIT 0
`define BV_CMP_LSB 1
`define EV_A_EN_BIT 0
`define EV_A_ACT_LSB 1
`define EV_B_EN_BIT 4
`define EV_B_ACT_LSB 5
`define INT_WRAP_BIT 0
`define INT_CMP_LSB 4

// masks and reset values
`define INT_MASK 8'h71
`define REG_RESET 8'h00
`define BV_RESET 4'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: timer_buffer_event_control_pkg.sv */
package timer_buffer_event_control_pkg;

	typedef enum logic [1:0] {
		CMD_NONE = 2'h0,
		CMD_UPDATE = 2'h1,
		CMD_RESTART = 2'h2,
		CMD_HARD_RESET = 2'h3
	} cmd_t;

	typedef enum logic [2:0] {
		count_rising_edge = 3'h0,
		count_either_edge = 3'h1,
		count_while_high = 3'h2,
		a_direction_count = 3'h3
	} act_a_t;

	typedef enum logic [2:0] {
		b_no_action = 3'h0,
		event_direction_count = 3'h3,
		restart_rising_edge = 3'h4,
		restart_either_edge = 3'h5,
		restart_while_high = 3'h6
	} act_b_t;

	// inputs from the counter core, all on aclk
	typedef struct packed {
		logic timer_enabled;
		logic update_cond;
		logic hw_dir_load;
		logic hw_dir;
		logic prescale_tick;
		logic [2:0] compare_match;
		logic wrap_event;
		logic [2:0] compare_buffer_write;
		logic period_buffer_write;
	} core_status_t;

	// commands to the counter core
	typedef struct packed {
		logic force_update;
		logic force_restart;
		logic force_hard_reset;
		logic buffer_transfer;
		logic count_step;
		logic lock_update;
		logic count_dir;
	} core_ctrl_t;

	typedef struct packed {
		logic aw_held;
		logic [7:0] aw_addr;
		logic w_held;
		logic [7:0] w_data;
		logic w_strb0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
		logic lock;
		logic dir;
		logic [3:0] bv;
		logic [7:0] ev_ctrl;
		logic [7:0] int_en;
		logic [7:0] flags;
		logic eva_s1;
		logic eva_s2;
		logic eva_prev;
		logic evb_s1;
		logic evb_s2;
		logic evb_prev;
		logic force_update;
		logic force_restart;
		logic force_hard_reset;
		logic buffer_transfer;
		logic count_step;
	} state_t;

endpackage

/* File: timer_buffer_event_control.sv */
`timescale 1ns/10ps
`include "timer_buffer_event_control_consts.svh"
// Summary of operation
// R1: command field always reads back as zero
// R2: command 1 update, 2 restart, 3 hard reset
// R3: hard reset ignored while timer is enabled
// R4: lock clear: buffers transfer on each update
// R5: lock set: no buffer transfer on update
// R6: direction 0 counts up, 1 counts down
// R7: hardware steers direction, software may write it
// R8: clear alias: writing one clears valid flag
// R9: set alias: writing one sets valid flag
// R10: compare buffer write sets its valid flag
// R11: period buffer write sets period valid flag
// R12: update condition clears all valid flags
// R13: action B 3: B level sets direction
// R14: action B 4,5,6 restart on edge/level
// R15: input B ignored unless its enable set
// R16: action A 0,1,2 edge or gated counting
// R17: action A 3: A level sets direction
// R18: input A ignored unless its enable set
// R19: enable bits 6..4 pass compare requests
// R20: enable bit 0 passes wrap request
// R21: compare flag set on match, W1C only
// R22: wrap flag set on top/bottom, W1C only
// R23: zero in alias leaves bit; aliases read flags
// R24: request line is flag and enable
module timer_buffer_event_control (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [7:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	// axi4-lite write data
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// axi4-lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [7:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// event routing network
	input wire logic event_a,
	input wire logic event_b,
	// counter core
	input timer_buffer_event_control_pkg::core_status_t core,
	output timer_buffer_event_control_pkg::core_ctrl_t ctrl,
	// interrupt requests
	output logic compare0_irq,
	output logic compare1_irq,
	output logic compare2_irq,
	output logic wrap_irq
);

	timer_buffer_event_control_pkg::state_t st_r;
	timer_buffer_event_control_pkg::state_t st_nxt;

	logic wr_go;
	logic wr_en;
	logic [5:0] wr_idx;
	logic [5:0] rd_idx;
	logic is_ctrl;
	logic do_hard;
	logic do_update;
	logic a_en;
	logic b_en;
	logic rise_a;
	logic any_a;
	logic rise_b;
	logic any_b;
	timer_buffer_event_control_pkg::cmd_t cmd;
	timer_buffer_event_control_pkg::act_a_t act_a;
	timer_buffer_event_control_pkg::act_b_t act_b;

	function automatic logic [5:0] idx_of(input logic [7:0] a);
		return a[7:2];
	endfunction

	function automatic logic mapped(input logic [5:0] i);
		return (i == `IDX_CTRL_CLEAR) || (i == `IDX_CTRL_SET) ||
			(i == `IDX_BV_CLEAR) || (i == `IDX_BV_SET) ||
			(i == `IDX_EV_CTRL) || (i == `IDX_INT_EN) ||
			(i == `IDX_INT_FLAGS);
	endfunction

	function automatic logic edge_hit(input logic any, input logic cur, input logic prev);
		return any ? (cur ^ prev) : (cur & ~prev);
	endfunction

	// one slot per channel: a new read waits until the response is gone; a new write is accepted but held until bvalid drops
	assign awready = !st_r.aw_held;
	assign wready = !st_r.w_held;
	assign arready = !st_r.rvalid;
	assign bvalid = st_r.bvalid;
	assign bresp = st_r.bresp;
	assign rvalid = st_r.rvalid;
	assign rresp = st_r.rresp;
	assign rdata = {24'h000000, st_r.rdata};

	assign ctrl.force_update = st_r.force_update;
	assign ctrl.force_restart = st_r.force_restart;
	assign ctrl.force_hard_reset = st_r.force_hard_reset;
	assign ctrl.buffer_transfer = st_r.buffer_transfer;
	assign ctrl.count_step = st_r.count_step;
	assign ctrl.lock_update = st_r.lock;
	assign ctrl.count_dir = st_r.dir; // R6

	assign compare0_irq = st_r.flags[`INT_CMP_LSB] & st_r.int_en[`INT_CMP_LSB]; // R19 R24
	assign compare1_irq = st_r.flags[`INT_CMP_LSB + 1] & st_r.int_en[`INT_CMP_LSB + 1]; // R19
	assign compare2_irq = st_r.flags[`INT_CMP_LSB + 2] & st_r.int_en[`INT_CMP_LSB + 2]; // R19
	assign wrap_irq = st_r.flags[`INT_WRAP_BIT] & st_r.int_en[`INT_WRAP_BIT]; // R20 R24

	always_comb begin
		st_nxt = st_r;
		wr_go = st_r.aw_held && st_r.w_held && !st_r.bvalid;
		wr_idx = idx_of(st_r.aw_addr);
		rd_idx = idx_of(araddr);
		wr_en = wr_go && st_r.w_strb0 && mapped(wr_idx);
		cmd = timer_buffer_event_control_pkg::cmd_t'(st_r.w_data[`CTRL_CMD_LSB +: 2]);
		act_a = timer_buffer_event_control_pkg::act_a_t'(st_r.ev_ctrl[`EV_A_ACT_LSB +: 3]);
		act_b = timer_buffer_event_control_pkg::act_b_t'(st_r.ev_ctrl[`EV_B_ACT_LSB +: 3]);
		a_en = st_r.ev_ctrl[`EV_A_EN_BIT]; // R18
		b_en = st_r.ev_ctrl[`EV_B_EN_BIT]; // R15
		rise_a = edge_hit(1'b0, st_r.eva_s2, st_r.eva_prev);
		any_a = edge_hit(1'b1, st_r.eva_s2, st_r.eva_prev);
		rise_b = edge_hit(1'b0, st_r.evb_s2, st_r.evb_prev);
		any_b = edge_hit(1'b1, st_r.evb_s2, st_r.evb_prev);
		is_ctrl = wr_en && ((wr_idx == `IDX_CTRL_CLEAR) || (wr_idx == `IDX_CTRL_SET));
		do_hard = is_ctrl && (cmd == timer_buffer_event_control_pkg::CMD_HARD_RESET) &&
			!core.timer_enabled; // R3
		do_update = core.update_cond ||
			(is_ctrl && (cmd == timer_buffer_event_control_pkg::CMD_UPDATE)); // R2

		// event inputs: two flops before any logic looks at them
		st_nxt.eva_s1 = event_a;
		st_nxt.eva_s2 = st_r.eva_s1;
		st_nxt.eva_prev = st_r.eva_s2;
		st_nxt.evb_s1 = event_b;
		st_nxt.evb_s2 = st_r.evb_s1;
		st_nxt.evb_prev = st_r.evb_s2;

		// write channel capture
		if (awvalid && !st_r.aw_held) begin
			st_nxt.aw_held = 1'b1;
			st_nxt.aw_addr = awaddr;
		end
		if (wvalid && !st_r.w_held) begin
			st_nxt.w_held = 1'b1;
			st_nxt.w_data = wdata[7:0];
			st_nxt.w_strb0 = wstrb[0];
		end
		if (st_r.bvalid && bready) begin
			st_nxt.bvalid = 1'b0;
		end
		if (wr_go) begin
			st_nxt.aw_held = 1'b0;
			st_nxt.w_held = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = mapped(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
		end

		// read channel; only the low byte carries data
		if (st_r.rvalid && rready) begin
			st_nxt.rvalid = 1'b0;
		end
		if (arvalid && !st_r.rvalid) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = mapped(rd_idx) ? `RESP_OKAY : `RESP_SLVERR;
			unique case (rd_idx)
				`IDX_CTRL_CLEAR, `IDX_CTRL_SET: begin
					st_nxt.rdata = {6'h00, st_r.lock, st_r.dir}; // R1
				end
				`IDX_BV_CLEAR, `IDX_BV_SET: begin
					st_nxt.rdata = {4'h0, st_r.bv}; // R23
				end
				`IDX_EV_CTRL: begin
					st_nxt.rdata = st_r.ev_ctrl;
				end
				`IDX_INT_EN: begin
					st_nxt.rdata = st_r.int_en;
				end
				`IDX_INT_FLAGS: begin
					st_nxt.rdata = st_r.flags;
				end
				default: begin
					st_nxt.rdata = `REG_RESET;
				end
			endcase
		end

		// direction from hardware first, software writes override it
		if (core.hw_dir_load) begin
			st_nxt.dir = core.hw_dir; // R7
		end
		if (a_en && (act_a == timer_buffer_event_control_pkg::a_direction_count)) begin
			st_nxt.dir = st_r.eva_s2; // R17
		end
		if (b_en && (act_b == timer_buffer_event_control_pkg::event_direction_count)) begin
			st_nxt.dir = st_r.evb_s2; // R13
		end

		// buffer valid flags: sw clear, then update clear, then sets win
		if (wr_en && (wr_idx == `IDX_BV_CLEAR)) begin
			st_nxt.bv = st_r.bv & ~st_r.w_data[3:0]; // R8 R23
		end
		if (do_update) begin
			st_nxt.bv = `BV_RESET; // R12
		end
		if (wr_en && (wr_idx == `IDX_BV_SET)) begin
			st_nxt.bv = st_nxt.bv | st_r.w_data[3:0]; // R9 R23
		end

		// software writes to control, event and interrupt registers
		if (wr_en && (wr_idx == `IDX_CTRL_CLEAR)) begin
			if (st_r.w_data[`CTRL_LOCK_BIT]) begin
				st_nxt.lock = 1'b0;
			end
			if (st_r.w_data[`CTRL_DIR_BIT]) begin
				st_nxt.dir = 1'b0; // R7
			end
		end
		if (wr_en && (wr_idx == `IDX_CTRL_SET)) begin
			if (st_r.w_data[`CTRL_LOCK_BIT]) begin
				st_nxt.lock = 1'b1;
			end
			if (st_r.w_data[`CTRL_DIR_BIT]) begin
				st_nxt.dir = 1'b1; // R7
			end
		end
		if (wr_en && (wr_idx == `IDX_EV_CTRL)) begin
			st_nxt.ev_ctrl = st_r.w_data;
		end
		if (wr_en && (wr_idx == `IDX_INT_EN)) begin
			st_nxt.int_en = st_r.w_data & `INT_MASK;
		end
		if (wr_en && (wr_idx == `IDX_INT_FLAGS)) begin
			st_nxt.flags = st_r.flags & ~(st_r.w_data & `INT_MASK); // R21 R22
		end

		// hard reset returns the control state to its reset values
		if (do_hard) begin
			st_nxt.lock = 1'b0;
			st_nxt.dir = 1'b0;
			st_nxt.bv = `BV_RESET;
			st_nxt.ev_ctrl = `REG_RESET;
			st_nxt.int_en = `REG_RESET;
			st_nxt.flags = `REG_RESET;
		end

		// hardware sets win over any clear in the same cycle
		st_nxt.bv[`BV_CMP_LSB +: 3] = st_nxt.bv[`BV_CMP_LSB +: 3] |
			core.compare_buffer_write; // R10
		st_nxt.bv[`BV_PER_BIT] = st_nxt.bv[`BV_PER_BIT] | core.period_buffer_write; // R11
		st_nxt.flags[`INT_CMP_LSB +: 3] = st_nxt.flags[`INT_CMP_LSB +: 3] |
			core.compare_match; // R21
		st_nxt.flags[`INT_WRAP_BIT] = st_nxt.flags[`INT_WRAP_BIT] | core.wrap_event; // R22

		// per-cycle commands to the counter core; software commands last one cycle
		st_nxt.force_update = is_ctrl && (cmd == timer_buffer_event_control_pkg::CMD_UPDATE); // R2
		st_nxt.force_hard_reset = do_hard; // R2 R3
		st_nxt.buffer_transfer = do_update && !st_r.lock; // R4 R5
		st_nxt.force_restart = is_ctrl &&
			(cmd == timer_buffer_event_control_pkg::CMD_RESTART); // R2
		if (b_en) begin
			unique case (act_b)
				timer_buffer_event_control_pkg::restart_rising_edge: begin
					st_nxt.force_restart = st_nxt.force_restart | rise_b; // R14
				end
				timer_buffer_event_control_pkg::restart_either_edge: begin
					st_nxt.force_restart = st_nxt.force_restart | any_b; // R14
				end
				timer_buffer_event_control_pkg::restart_while_high: begin
					st_nxt.force_restart = st_nxt.force_restart | st_r.evb_s2; // R14
				end
				default: begin
				end
			endcase
		end

		// with input A off the counter runs on the prescaled tick
		st_nxt.count_step = core.prescale_tick;
		if (a_en) begin
			unique case (act_a)
				timer_buffer_event_control_pkg::count_rising_edge: begin
					st_nxt.count_step = rise_a; // R16
				end
				timer_buffer_event_control_pkg::count_either_edge: begin
					st_nxt.count_step = any_a; // R16
				end
				timer_buffer_event_control_pkg::count_while_high: begin
					st_nxt.count_step = core.prescale_tick & st_r.eva_s2; // R16
				end
				timer_buffer_event_control_pkg::a_direction_count: begin
					st_nxt.count_step = core.prescale_tick; // R17
				end
				default: begin
					st_nxt.count_step = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// R6: dir is handed to the core as-is; 0 means up, 1 means down

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_cmd_zero;
		arvalid && arready && (idx_of(araddr) == `IDX_CTRL_SET) |=> rdata[3:2] == 2'h0;
	endproperty
	a_cmd_zero: assert property (p_cmd_zero) else $error("command field read nonzero"); // R1

	property p_cmd_update;
		is_ctrl && (cmd == timer_buffer_event_control_pkg::CMD_UPDATE)
			|=> ctrl.force_update ##1 !ctrl.force_update;
	endproperty
	a_cmd_update: assert property (p_cmd_update) else $error("update pulse wrong"); // R2

	property p_hard_blocked;
		is_ctrl && (cmd == timer_buffer_event_control_pkg::CMD_HARD_RESET) &&
			core.timer_enabled |=> !ctrl.force_hard_reset;
	endproperty
	a_hard_blocked: assert property (p_hard_blocked) else $error("hard reset while enabled"); // R3

	property p_transfer;
		core.update_cond && !st_r.lock |=> ctrl.buffer_transfer;
	endproperty
	a_transfer: assert property (p_transfer) else $error("buffer transfer missing"); // R4

	property p_locked;
		st_r.lock && !wr_go |=> !ctrl.buffer_transfer;
	endproperty
	a_locked: assert property (p_locked) else $error("transfer while locked"); // R5

	property p_bv_set;
		core.compare_buffer_write[0] |=> st_r.bv[`BV_CMP_LSB];
	endproperty
	a_bv_set: assert property (p_bv_set) else $error("compare valid not set"); // R10

	property p_bv_clear;
		core.update_cond && !core.period_buffer_write && (core.compare_buffer_write == 3'h0) &&
			!wr_go |=> st_r.bv == 4'h0;
	endproperty
	a_bv_clear: assert property (p_bv_clear) else $error("valid flags not cleared"); // R12

	property p_restart_high;
		b_en && (act_b == timer_buffer_event_control_pkg::restart_while_high) &&
			st_r.evb_s2 |=> ctrl.force_restart;
	endproperty
	a_restart_high: assert property (p_restart_high) else $error("no level restart"); // R14

	property p_b_off;
		!b_en && !is_ctrl |=> !ctrl.force_restart;
	endproperty
	a_b_off: assert property (p_b_off) else $error("restart with input B off"); // R15

	property p_count_rise;
		a_en && (act_a == timer_buffer_event_control_pkg::count_rising_edge) && !wr_go &&
			$rose(st_r.eva_s2) |=> ctrl.count_step ##1 !ctrl.count_step;
	endproperty
	a_count_rise: assert property (p_count_rise) else $error("rising edge step wrong"); // R16

	property p_cmp_irq;
		core.compare_match[0] && st_r.int_en[`INT_CMP_LSB] && !wr_go
			|=> compare0_irq ##1 (compare0_irq || $past(wr_go));
	endproperty
	a_cmp_irq: assert property (p_cmp_irq) else $error("compare request missing"); // R21

	c_write: cover property (wr_go && (wr_idx == `IDX_BV_SET));
	c_read: cover property (rvalid && rready);
	c_restart: cover property (ctrl.force_restart);
	c_irq: cover property ($rose(wrap_irq));

endmodule

/* File: event_net_model.sv */
`timescale 1ns/10ps
module event_net_model (
	// clock
	input wire logic aclk,
	// event levels towards the timer
	output logic event_a,
	output logic event_b
);
	initial begin
		event_a = 1'b0;
		event_b = 1'b0;
	end

	// raises one line for a number of cycles, then drops it back to idle low
	task automatic pulse(input logic sel_b, input int cycles);
		@(posedge aclk);
		if (sel_b) begin
			event_b <= 1'b1;
		end else begin
			event_a <= 1'b1;
		end
		repeat (cycles) @(posedge aclk);
		event_a <= 1'b0;
		event_b <= 1'b0;
	endtask
endmodule

/* File: tb_timer_buffer_event_control.sv */
`timescale 1ns/10ps
`include "timer_buffer_event_control_consts.svh"
module tb_timer_buffer_event_control;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, event_a, event_b;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, resp;
	logic compare0_irq, compare1_irq, compare2_irq, wrap_irq;
	timer_buffer_event_control_pkg::core_status_t core;
	timer_buffer_event_control_pkg::core_ctrl_t ctrl;
	logic [4:0] pv;
	int err_total, n_tests, i;
	int cnt [5];
	int base [5];
	logic [7:0] evc [8] = '{8'h01, 8'h03, 8'h00, 8'h05, 8'h90, 8'hb0, 8'hd0, 8'hc0};
	int es [8] = '{1, 2, 0, 4, 0, 0, 0, 0};
	int er [8] = '{0, 0, 0, 0, 1, 2, 4, 0};

	timer_buffer_event_control u_timer_buffer_event_control (
		.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.event_a(event_a), .event_b(event_b), .core(core), .ctrl(ctrl),
		.compare0_irq(compare0_irq), .compare1_irq(compare1_irq),
		.compare2_irq(compare2_irq), .wrap_irq(wrap_irq)
	);

	event_net_model u_event_net_model (.aclk(aclk), .event_a(event_a), .event_b(event_b));

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// pulse counters; tests compare differences so no second driver is needed
	assign pv = {ctrl.count_step, ctrl.buffer_transfer, ctrl.force_hard_reset,
		ctrl.force_restart, ctrl.force_update};
	always @(posedge aclk) begin
		for (int k = 0; k < 5; k++) begin
			cnt[k] <= aresetn ? cnt[k] + int'(pv[k]) : 0;
		end
	end

	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic timeout(input int n);
		if (n >= 64) begin
			err_total++;
			finish_test();
		end
	endtask

	task automatic axi_write(input logic [5:0] idx, input logic [7:0] d);
		int n;
		logic aw_ok, w_ok;
		n = 0;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awaddr <= {idx, 2'b00};
		wdata <= {24'h0, d};
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok) && n < 64) begin
			@(posedge aclk);
			n++;
			if (!aw_ok && awready) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do begin
			@(posedge aclk);
			n++;
		end while (!bvalid && n < 64);
		resp = bresp;
		timeout(n);
	endtask

	task automatic axi_read(input logic [5:0] idx);
		int n;
		n = 0;
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
		end while (!arready && n < 64);
		arvalid <= 1'b0;
		do begin
			@(posedge aclk);
			n++;
		end while (!rvalid && n < 64);
		rd = rdata;
		resp = rresp;
		timeout(n);
	endtask

	task automatic rd_chk(input logic [5:0] idx, input logic [7:0] e);
		axi_read(idx);
		chk(rd, {24'h0, e});
	endtask

	// one-cycle strobe from the counter core, then time for the answer to land
	task automatic core_pulse(input logic [12:0] v);
		core <= v;
		@(posedge aclk);
		core <= '0;
		repeat (3) @(posedge aclk);
	endtask

	task automatic snap();
		base = cnt;
	endtask

	task automatic chk_d(input int k, input int e);
		chk(32'(cnt[k] - base[k]), 32'(e));
	endtask

	initial begin
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		wstrb = '0;
		core = '0;
		err_total = 0;
		n_tests = 0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd_chk(`IDX_BV_CLEAR, 8'h00);
		rd_chk(`IDX_BV_SET, 8'h00);
		rd_chk(`IDX_EV_CTRL, 8'h00);
		rd_chk(`IDX_INT_EN, 8'h00);
		axi_read(6'h3f);
		chk(32'(resp), 32'(`RESP_SLVERR));
		axi_write(6'h3f, 8'h00);
		chk(32'(resp), 32'(`RESP_SLVERR));
		// each nonzero command code together with the lock bit; command never reads back
		for (i = 1; i < 4; i++) begin
			snap();
			axi_write(`IDX_CTRL_SET, 8'((i << 2) | 2));
			repeat (3) @(posedge aclk);
			chk_d(i - 1, 1);
			rd_chk(`IDX_CTRL_SET, (i == 3) ? 8'h00 : 8'h02);
		end
		core.timer_enabled <= 1'b1;
		snap();
		axi_write(`IDX_CTRL_SET, 8'h0d);
		repeat (3) @(posedge aclk);
		chk_d(2, 0);
		chk(32'(ctrl.count_dir), 32'h1);
		core_pulse(13'h0400);
		chk(32'(ctrl.count_dir), 32'h0);
		axi_write(`IDX_CTRL_SET, 8'h02);
		chk(32'(ctrl.lock_update), 32'h1);
		snap();
		core_pulse(13'h0800);
		chk_d(3, 0);
		axi_write(`IDX_CTRL_CLEAR, 8'h02);
		snap();
		core_pulse(13'h0800);
		chk_d(3, 1);
		axi_write(`IDX_BV_SET, 8'h05);
		rd_chk(`IDX_BV_SET, 8'h05);
		axi_write(`IDX_BV_CLEAR, 8'h01);
		rd_chk(`IDX_BV_CLEAR, 8'h04);
		core_pulse(13'h0008);
		core_pulse(13'h0001);
		rd_chk(`IDX_BV_SET, 8'h0d);
		core_pulse(13'h0800);
		rd_chk(`IDX_BV_CLEAR, 8'h00);
		// event actions: four-cycle pulse on A (first four rows) or B; last row has B off
		for (i = 0; i < 8; i++) begin
			axi_write(`IDX_EV_CTRL, evc[i]);
			rd_chk(`IDX_EV_CTRL, evc[i]);
			snap();
			core.prescale_tick <= (i == 3);
			u_event_net_model.pulse(i >= 4, 4);
			repeat (6) @(posedge aclk);
			core.prescale_tick <= 1'b0;
			chk_d(4, es[i]);
			chk_d(1, er[i]);
		end
		// level steering of direction from input A, then from input B
		for (i = 0; i < 2; i++) begin
			axi_write(`IDX_EV_CTRL, (i == 0) ? 8'h07 : 8'h70);
			u_event_net_model.pulse(i == 1, 4);
			chk(32'(ctrl.count_dir), 32'h1);
			repeat (6) @(posedge aclk);
			chk(32'(ctrl.count_dir), 32'h0);
		end
		axi_write(`IDX_EV_CTRL, 8'h00);
		axi_write(`IDX_INT_EN, 8'hff);
		rd_chk(`IDX_INT_EN, 8'h71);
		core_pulse(13'h00f0);
		chk(32'({compare2_irq, compare1_irq, compare0_irq, wrap_irq}), 32'hf);
		rd_chk(`IDX_INT_FLAGS, 8'h71);
		axi_write(`IDX_INT_FLAGS, 8'h10);
		chk(32'({compare2_irq, compare1_irq, compare0_irq, wrap_irq}), 32'hd);
		axi_write(`IDX_INT_EN, 8'h00);
		chk(32'({compare2_irq, compare1_irq, compare0_irq, wrap_irq}), 32'h0);
		rd_chk(`IDX_INT_FLAGS, 8'h61);
		finish_test();
	end
endmodule
